// ### hw/bss_exec.sv
// bit test skip when clear and bit force high executor
`timescale 1ns/1ns
`default_nettype none
module bss_exec
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] rd_data_i,
  output bss_pkg::bss_file_rd_t file_rd_o,
  output bss_pkg::bss_file_wr_t file_wr_o,
  output logic [1:0] phase_o,
  output logic busy_o,
  output logic skip_cycle_o,
  output logic flags_we_o
);
  import bss_pkg::*;
  bss_phase_t phase;
  logic [13:0] ir;
  logic is_test;
  logic is_force;
  logic [7:0] data;
  logic skip;
  logic take_skip;
  logic [13:0] next_ir;
  logic next_is_test;
  logic next_is_force;
  logic [7:0] next_data;
  logic next_skip;
  logic next_take_skip;
  bss_file_rd_t rd;
  bss_file_rd_t next_rd;
  bss_file_wr_t wr;
  bss_file_wr_t next_wr;
  logic [2:0] bit_sel;
  logic [7:0] bit_mask;
  logic [7:0] forced_data;
  logic tested_bit;
  logic [3:0] word_op;
  logic [6:0] word_addr;
  logic word_is_test;
  logic word_is_force;

  bss_phase_gen u_phase
  (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .phase_o(phase)
  );

  assign bit_sel = ir[bss_bit_hi:bss_bit_lo];
  assign word_op = instr_i[bss_op_hi:bss_op_lo];
  assign word_addr = instr_i[bss_addr_hi:bss_addr_lo];
  assign word_is_test = (word_op == bss_op_test_clear);
  assign word_is_force = (word_op == bss_op_force_high);

  // one select line per data bit
  genvar gi;
  generate
    for (gi = 0; gi < bss_data_w; gi++)
    begin : g_bit
      assign bit_mask[gi] = (bit_sel == 3'(gi));
    end
  endgenerate

  assign forced_data = data | bit_mask;
  assign tested_bit = |(data & bit_mask);

  // control group: word, decode flags, skip state
  always_comb
  begin
    next_ir = ir;
    next_is_test = is_test;
    next_is_force = is_force;
    next_skip = skip;
    next_take_skip = take_skip;
    unique case (phase)
      bss_q1:
      begin
        next_ir = instr_i;
        next_skip = take_skip;
        next_take_skip = 1'b0;
        // fetched word becomes a nop during a skip cycle
        next_is_test = !take_skip && word_is_test;
        next_is_force = !take_skip && word_is_force;
      end
      bss_q3:
      begin
        if (is_test)
          next_take_skip = !tested_bit;
      end
      bss_q2, bss_q4:
      begin
        next_ir = ir;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ir <= bss_word_zero;
      is_test <= 1'b0;
      is_force <= 1'b0;
      skip <= 1'b0;
      take_skip <= 1'b0;
    end
    else
    begin
      ir <= next_ir;
      is_test <= next_is_test;
      is_force <= next_is_force;
      skip <= next_skip;
      take_skip <= next_take_skip;
    end
  end

  // data group: read capture and bit processing
  always_comb
  begin
    next_data = data;
    unique case (phase)
      bss_q2:
      begin
        next_data = rd_data_i;
      end
      bss_q3:
      begin
        if (is_force)
          next_data = forced_data;
      end
      bss_q1, bss_q4:
      begin
        next_data = data;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      data <= bss_data_zero;
    else
      data <= next_data;
  end

  // file port group: read strobe in q2, write strobe in next q1
  always_comb
  begin
    next_rd = '0;
    next_wr = '0;
    unique case (phase)
      bss_q1:
      begin
        next_rd.en = next_is_test || next_is_force;
        next_rd.addr = word_addr;
      end
      bss_q4:
      begin
        next_wr.en = is_force;
        next_wr.addr = ir[bss_addr_hi:bss_addr_lo];
        next_wr.data = data;
      end
      bss_q2, bss_q3:
      begin
        next_wr = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd <= '0;
      wr <= '0;
    end
    else
    begin
      rd <= next_rd;
      wr <= next_wr;
    end
  end

  logic [1:0] phase_q;
  logic busy_q;
  logic flags_we_q;
  logic [1:0] next_phase_q;
  logic next_busy_q;
  logic next_flags_we_q;

  // status group: phase echo, busy and flag write strobe
  always_comb
  begin
    next_phase_q = phase;
    next_busy_q = is_test || is_force || skip;
    next_flags_we_q = 1'b0;
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      phase_q <= bss_q1;
      busy_q <= 1'b0;
      flags_we_q <= 1'b0;
    end
    else
    begin
      phase_q <= next_phase_q;
      busy_q <= next_busy_q;
      flags_we_q <= next_flags_we_q;
    end
  end

  assign file_rd_o = rd;
  assign file_wr_o = wr;
  assign phase_o = phase_q;
  assign busy_o = busy_q;
  assign skip_cycle_o = skip;
  assign flags_we_o = flags_we_q;
endmodule
`default_nettype wire

// ### hw/bss_phase_gen.sv
// phase sequencer: four clocks per instruction cycle
`timescale 1ns/1ns
`default_nettype none
module bss_phase_gen
(
  input wire logic clock_i,
  input wire logic reset_i,
  output bss_pkg::bss_phase_t phase_o
);
  import bss_pkg::*;
  bss_phase_t phase;
  bss_phase_t next_phase;

  always_comb
  begin
    unique case (phase)
      bss_q1: next_phase = bss_q2;
      bss_q2: next_phase = bss_q3;
      bss_q3: next_phase = bss_q4;
      bss_q4: next_phase = bss_q1;
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      phase <= bss_q1;
    else
      phase <= next_phase;
  end

  assign phase_o = phase;
endmodule
`default_nettype wire

// ### hw/bss_pkg.sv
// package: constants and carriers for the bit set and skip executor
package bss_pkg;
  localparam int unsigned bss_word_w = 14;
  localparam int unsigned bss_addr_w = 7;
  localparam int unsigned bss_data_w = 8;
  localparam int unsigned bss_bit_w = 3;
  localparam int unsigned bss_op_hi = 13;
  localparam int unsigned bss_op_lo = 10;
  localparam int unsigned bss_bit_hi = 9;
  localparam int unsigned bss_bit_lo = 7;
  localparam int unsigned bss_addr_hi = 6;
  localparam int unsigned bss_addr_lo = 0;
  localparam logic [3:0] bss_op_test_clear = 4'h6;
  localparam logic [3:0] bss_op_force_high = 4'h5;
  localparam logic [7:0] bss_data_zero = 8'h00;
  localparam logic [6:0] bss_addr_zero = 7'h00;
  localparam logic [2:0] bss_bit_zero = 3'h0;
  localparam logic [13:0] bss_word_zero = 14'h0000;

  typedef enum logic [1:0]
  {
    bss_q1 = 2'b00,
    bss_q2 = 2'b01,
    bss_q3 = 2'b11,
    bss_q4 = 2'b10
  } bss_phase_t;

  typedef struct packed
  {
    logic [6:0] addr;
    logic [7:0] data;
    logic en;
  } bss_file_wr_t;

  typedef struct packed
  {
    logic [6:0] addr;
    logic en;
  } bss_file_rd_t;
endpackage

// ### sim/bss_exec_sva.sv
// checker for the bit set and skip executor
`timescale 1ns/1ns
`default_nettype none
module bss_chk
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0] rd_data_i,
  input wire bss_pkg::bss_file_rd_t file_rd_o,
  input wire bss_pkg::bss_file_wr_t file_wr_o,
  input wire logic [1:0] phase_o,
  input wire logic busy_o,
  input wire logic skip_cycle_o,
  input wire logic flags_we_o
);
  import bss_pkg::*;
  logic [13:0] w;
  logic t;
  logic h;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  always_ff @(posedge clock_i) w <= instr_i;
  assign t = file_rd_o.en && w[13:10] == 4'h6;
  assign h = rd_data_i[w[9:7]];
  chk_read_phase:
    assert property (file_rd_o.en |-> phase_o == 2'b00) else $error("rd");
  chk_decode_word:
    assert property ($rose(file_rd_o.en) |-> w[13:12] == 2'b01 && ^w[11:10]
      && file_rd_o.addr == w[6:0]) else $error("dec");
  chk_set_runs:
    assert property (t && h |-> ##4 !skip_cycle_o) else $error("run");
  chk_clear_skips:
    assert property (t && !h |-> ##4 skip_cycle_o) else $error("skip");
  chk_skip_len:
    assert property ($rose(skip_cycle_o) |-> skip_cycle_o[*4] ##1
      !skip_cycle_o) else $error("len");
  chk_skip_quiet:
    assert property (skip_cycle_o |-> !file_rd_o.en && !file_wr_o.en)
      else $error("quiet");
  chk_rmw_write:
    assert property (file_wr_o.en |-> $past(instr_i[13:10], 4) == 4'h5
      && file_wr_o.addr == $past(instr_i[6:0], 4) && file_wr_o.data ==
      ($past(rd_data_i, 3) | 8'h01 << $past(instr_i[9:7], 4)))
      else $error("rmw");
  chk_no_flags:
    assert property (!flags_we_o) else $error("flags");
  chk_busy_skip:
    assert property (skip_cycle_o |=> busy_o) else $error("busy");
  cover property (t && !h);
  cover property (t && h);
  cover property (file_wr_o.en);
endmodule
bind bss_exec bss_chk i_chk
(
  .clock_i, .reset_i, .instr_i, .rd_data_i, .file_rd_o, .file_wr_o,
  .phase_o, .busy_o, .skip_cycle_o, .flags_we_o
);
`default_nettype wire

// ### sim/tb_top.sv
// testbench for the bit set and skip executor
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import bss_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [13:0] instr_i = 14'h0;
  logic [7:0] rd_data_i = 8'h0;
  bss_file_rd_t rd;
  bss_file_wr_t wr;
  logic skip;
  logic flags;
  logic [1:0] phase;
  logic busy;
  logic [8:0] pw = 9'h0;
  logic pend = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  always #50 clock_i = ~clock_i;
  bss_exec i_dut (.clock_i, .reset_i, .instr_i, .rd_data_i, .file_rd_o(rd),
    .file_wr_o(wr), .phase_o(phase), .busy_o(busy), .skip_cycle_o(skip),
    .flags_we_o(flags));
  task automatic cmp(input string n, input logic [8:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] force_exp(input logic [7:0] d,
    input logic [2:0] b);
    return d | (8'h01 << b);
  endfunction
  task automatic stop_test;
    $display("checks %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one instruction cycle, entered at the edge before it starts
  task automatic run(input logic [3:0] op, input logic [7:0] d);
    logic [13:0] w;
    logic ex;
    w = {op, 10'($urandom)};
    ex = !pend && (op == 4'h5 || op == 4'h6);
    instr_i <= w;
    @(negedge clock_i);
    cmp("wr", pw[0] ? wr[8:0] : {8'h00, wr.en}, pw);
    @(posedge clock_i);
    rd_data_i <= d;
    @(negedge clock_i);
    cmp("skip", {7'h00, skip, rd.en}, {7'h00, pend, ex});
    cmp("flag", {8'h00, flags}, 9'h000);
    @(posedge clock_i);
    rd_data_i <= ~d;
    @(negedge clock_i);
    cmp("busy", {8'h00, busy}, {8'h00, ex || pend});
    cmp("phase", {7'h00, phase}, {7'h00, bss_q2});
    repeat (2) @(posedge clock_i);
    pw = {force_exp(d, w[9:7]), ex && op == 4'h5};
    pw = pw[0] ? pw : 9'h000;
    pend = ex && op == 4'h6 && !d[w[9:7]];
  endtask
  initial
  begin
    repeat (1000) @(posedge clock_i);
    bad_count++;
    stop_test();
  end
  initial
  begin
    void'($urandom(65716));
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    run(4'h6, 8'h00);
    run(4'h5, 8'hff);
    run(4'h6, 8'hff);
    run(4'h5, 8'h00);
    repeat (40) run(4'($urandom_range(4, 7)), 8'($urandom));
    run(4'h0, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
